// ### resq_consts.svh
// constants for the rail enable sequencer: offsets, fields, reset values, timing
// assumes a 50 MHz clock and a plain byte-wide register port
`ifndef RESQ_CONSTS_SVH
`define RESQ_CONSTS_SVH

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define RESQ_OFS_R3_MASK_A 8'h0a
`define RESQ_OFS_R3_SRC_MASK_B 8'h0e
`define RESQ_OFS_R3_DELAYS 8'h0f
`define RESQ_OFS_R4_MASK_A 8'h10
`define RESQ_OFS_STATUS 8'h20

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define RESQ_SRC_LSB 2
`define RESQ_SRC_MSB 4
`define RESQ_RISE_LSB 0
`define RESQ_RISE_MSB 2
`define RESQ_FALL_LSB 3
`define RESQ_FALL_MSB 5
`define RESQ_MASKB_LOAD_SWITCH_B1 0
`define RESQ_MASKB_SWB2 1

// ------------------------------------------------------------
// reset values (one-time-programmable defaults)
// ------------------------------------------------------------
`define RESQ_RST_MASK_A 8'h00
`define RESQ_RST_SRC_MASK_B 8'h00
`define RESQ_RST_DELAYS 8'h00
`define RESQ_RST_R4_MASK_A 8'h00

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define RESQ_CLK_HZ 50000000
`define RESQ_UNIT_MS 2
`define RESQ_UNIT_CYC ((`RESQ_CLK_HZ / 1000) * `RESQ_UNIT_MS)

`endif

// ### resq_pkg.sv
// types for the rail enable sequencer
// assumes resq_consts.svh holds all numbers
package resq_pkg;

   typedef enum logic [2:0] {
      RESQ_SRC_CONTROL_INPUT_1 = 3'b000,
      RESQ_SRC_CONTROL_INPUT_2 = 3'b001,
      RESQ_SRC_CONTROL_INPUT_5 = 3'b010,
      RESQ_SRC_CONTROL_INPUT_4 = 3'b011,
      RESQ_SRC_CONTROL_INPUT_3 = 3'b100,
      RESQ_SRC_CTL34 = 3'b101,
      RESQ_SRC_CONTROL_INPUT_6 = 3'b110,
      RESQ_SRC_ON = 3'b111
   } resq_src_t;

   typedef enum logic [1:0] {
      RESQ_ST_OFF = 2'b00,
      RESQ_ST_RISE = 2'b01,
      RESQ_ST_ON = 2'b10,
      RESQ_ST_FALL = 2'b11
   } resq_state_t;

   // power-good inputs of the other rails
   typedef struct packed {
      logic linear_regulator_3;
      logic linear_regulator_2;
      logic load_switch_a1;
      logic switching_rail_6;
      logic switching_rail_5;
      logic switching_rail_4;
      logic switching_rail_2;
      logic switching_rail_1;
   } resq_good_a_t;

   typedef struct packed {
      logic load_switch_b2_linear1;
      logic load_switch_b1;
   } resq_good_b_t;

   typedef struct packed {
      logic control_input_6;
      logic control_input_5;
      logic control_input_4;
      logic control_input_3;
      logic control_input_2;
      logic control_input_1;
   } resq_ctl_t;

endpackage

// ### resq_rail_enable_sequencer.sv
// enable sequencer for the third switching rail, with its register port
// assumes pins are asynchronous to clock and software uses the plain register port
// How it works
// R1 - each bit of the rail's first mask register drops one other rail's power-good from the enable when set.
// R2 - bit 0 of the second register drops the first load switch's power-good when set.
// R3 - bit 1 of the second register drops the second load switch plus linear 1 power-good when set.
// R4 - the three-bit source field picks control input 1, 2, 5, 4, 3, 3 and 4 together, or 6.
// R5 - source code 111 feeds a constant one so the rail enables with no pin.
// R6 - the rising edge of the enable is acted on after none, 2, 4, 8, 16, 24, 32 or 64 ms.
// R7 - the falling edge is delayed with the same code-to-delay mapping.
// R8 - the enable is source AND every unmasked power-good, each edge timed by a counter.
`timescale 1ns/1ps
`include "resq_consts.svh"

module resq_rail_enable_sequencer
   import resq_pkg::*;
#(
   parameter int unsigned UNIT_CYC = `RESQ_UNIT_CYC
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire resq_ctl_t ctl_in,
   input wire resq_good_a_t good_a_in,
   input wire resq_good_b_t good_b_in,
   output logic rail3_enable
);

   // ------------------------------------------------------------
   // delay code to 2 ms units
   // ------------------------------------------------------------
   function automatic logic [5:0] resq_units(input logic [2:0] code);
      case (code)
         3'h0: resq_units = 6'h00;
         3'h1: resq_units = 6'h01;
         3'h2: resq_units = 6'h02;
         3'h3: resq_units = 6'h04;
         3'h4: resq_units = 6'h08;
         3'h5: resq_units = 6'h0c;
         3'h6: resq_units = 6'h10;
         default: resq_units = 6'h20;
      endcase
   endfunction

   // ------------------------------------------------------------
   // input synchronisers
   // ------------------------------------------------------------
   logic [15:0] sync1_q, sync2_q, sync1_d;
   resq_ctl_t ctl_s;
   resq_good_a_t good_a_s;
   resq_good_b_t good_b_s;

   always_comb begin
      sync1_d = {ctl_in, good_a_in, good_b_in};
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         sync1_q <= 16'h0000;
         sync2_q <= 16'h0000;
      end else begin
         sync1_q <= sync1_d;
         sync2_q <= sync1_q;
      end
   end

   assign {ctl_s, good_a_s, good_b_s} = sync2_q;

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   logic [7:0] mask_a_q, mask_a_d;
   logic [7:0] src_b_q, src_b_d;
   logic [7:0] dly_q, dly_d;
   logic [7:0] r4_mask_q, r4_mask_d;
   logic [7:0] rdata_q, rdata_d;
   resq_state_t state_q, state_d;
   logic [5:0] units_q, units_d;
   logic [31:0] tick_q, tick_d;
   logic req;

   always_comb begin
      mask_a_d = mask_a_q;
      src_b_d = src_b_q;
      dly_d = dly_q;
      r4_mask_d = r4_mask_q;
      rdata_d = 8'h00;
      if (reg_wr) begin
         case (reg_addr)
            `RESQ_OFS_R3_MASK_A: mask_a_d = reg_wdata;
            `RESQ_OFS_R3_SRC_MASK_B: src_b_d = reg_wdata;
            `RESQ_OFS_R3_DELAYS: dly_d = reg_wdata;
            `RESQ_OFS_R4_MASK_A: r4_mask_d = reg_wdata;
            default: ;
         endcase
      end
      if (reg_rd) begin
         case (reg_addr)
            `RESQ_OFS_R3_MASK_A: rdata_d = mask_a_q;
            `RESQ_OFS_R3_SRC_MASK_B: rdata_d = src_b_q;
            `RESQ_OFS_R3_DELAYS: rdata_d = dly_q;
            `RESQ_OFS_R4_MASK_A: rdata_d = r4_mask_q;
            `RESQ_OFS_STATUS: rdata_d = {5'h00, req, state_q};
            default: rdata_d = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         mask_a_q <= `RESQ_RST_MASK_A;
         src_b_q <= `RESQ_RST_SRC_MASK_B;
         dly_q <= `RESQ_RST_DELAYS;
         r4_mask_q <= `RESQ_RST_R4_MASK_A;
         rdata_q <= 8'h00;
      end else begin
         mask_a_q <= mask_a_d;
         src_b_q <= src_b_d;
         dly_q <= dly_d;
         r4_mask_q <= r4_mask_d;
         rdata_q <= rdata_d;
      end
   end

   assign reg_rdata = rdata_q;

   // ------------------------------------------------------------
   // enable condition
   // ------------------------------------------------------------
   logic src_sel;
   logic goods_ok;
   resq_src_t src;

   always_comb begin
      src = resq_src_t'(src_b_q[`RESQ_SRC_MSB:`RESQ_SRC_LSB]);
      case (src) // R4
         RESQ_SRC_CONTROL_INPUT_1: src_sel = ctl_s.control_input_1;
         RESQ_SRC_CONTROL_INPUT_2: src_sel = ctl_s.control_input_2;
         RESQ_SRC_CONTROL_INPUT_5: src_sel = ctl_s.control_input_5;
         RESQ_SRC_CONTROL_INPUT_4: src_sel = ctl_s.control_input_4;
         RESQ_SRC_CONTROL_INPUT_3: src_sel = ctl_s.control_input_3;
         RESQ_SRC_CTL34: src_sel = ctl_s.control_input_3 & ctl_s.control_input_4;
         RESQ_SRC_CONTROL_INPUT_6: src_sel = ctl_s.control_input_6;
         RESQ_SRC_ON: src_sel = 1'b1; // R5
         default: src_sel = 1'b0;
      endcase
      goods_ok = &(good_a_s | mask_a_q); // R1
      goods_ok = goods_ok & (good_b_s.load_switch_b1 | src_b_q[`RESQ_MASKB_LOAD_SWITCH_B1]); // R2
      goods_ok = goods_ok & (good_b_s.load_switch_b2_linear1 | src_b_q[`RESQ_MASKB_SWB2]); // R3
      req = src_sel & goods_ok; // R8
   end

   // ------------------------------------------------------------
   // edge delay state machine
   // ------------------------------------------------------------
   // an edge that reverses mid-delay cancels the wait, so short glitches never reach the rail
   always_comb begin
      state_d = state_q;
      units_d = units_q;
      tick_d = tick_q;
      case (state_q)
         RESQ_ST_OFF: begin
            if (req) begin
               units_d = resq_units(dly_q[`RESQ_RISE_MSB:`RESQ_RISE_LSB]); // R6
               tick_d = 32'h0;
               state_d = RESQ_ST_RISE;
            end
         end
         RESQ_ST_RISE: begin
            if (!req) begin
               state_d = RESQ_ST_OFF;
            end else if (units_q == 6'h00) begin
               state_d = RESQ_ST_ON; // R8
            end else if (tick_q == UNIT_CYC - 1) begin
               tick_d = 32'h0;
               units_d = units_q - 6'h01;
            end else begin
               tick_d = tick_q + 32'h1;
            end
         end
         RESQ_ST_ON: begin
            if (!req) begin
               units_d = resq_units(dly_q[`RESQ_FALL_MSB:`RESQ_FALL_LSB]); // R7
               tick_d = 32'h0;
               state_d = RESQ_ST_FALL;
            end
         end
         RESQ_ST_FALL: begin
            if (req) begin
               state_d = RESQ_ST_ON;
            end else if (units_q == 6'h00) begin
               state_d = RESQ_ST_OFF; // R8
            end else if (tick_q == UNIT_CYC - 1) begin
               tick_d = 32'h0;
               units_d = units_q - 6'h01;
            end else begin
               tick_d = tick_q + 32'h1;
            end
         end
         default: state_d = RESQ_ST_OFF;
      endcase
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state_q <= RESQ_ST_OFF;
         units_q <= 6'h00;
         tick_q <= 32'h0;
      end else begin
         state_q <= state_d;
         units_q <= units_d;
         tick_q <= tick_d;
      end
   end

   assign rail3_enable = (state_q == RESQ_ST_ON) || (state_q == RESQ_ST_FALL);

endmodule // resq_rail_enable_sequencer

// ### resq_seq_properties.sv
// checker for the rail enable sequencer, bound to its top-level ports
// assumes two-flop pin synchronisers and a one-cycle registered read port
`timescale 1ns/1ps
`include "resq_consts.svh"
module resq_seq_properties
   import resq_pkg::*;
#(
   parameter int unsigned UNIT_CYC = `RESQ_UNIT_CYC
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire resq_ctl_t ctl_in,
   input wire resq_good_a_t good_a_in,
   input wire resq_good_b_t good_b_in,
   input wire logic rail3_enable
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   // ----
   // shadow of the registers and of the synchronised request
   // ----
   logic [7:0] sh_q [4];
   logic [15:0] s1_q, s2_q;
   logic [7:0] shv, sel;
   logic [1:0] idx;
   logic hit, req;
   always_comb begin
      hit = 1'b1;
      idx = 2'd0;
      case (reg_addr)
         `RESQ_OFS_R3_MASK_A: idx = 2'd0;
         `RESQ_OFS_R3_SRC_MASK_B: idx = 2'd1;
         `RESQ_OFS_R3_DELAYS: idx = 2'd2;
         `RESQ_OFS_R4_MASK_A: idx = 2'd3;
         default: hit = 1'b0;
      endcase
      shv = sh_q[idx];
   end
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         sh_q <= '{default: 8'h00};
         s1_q <= 16'h0000;
         s2_q <= 16'h0000;
      end else begin
         s1_q <= {ctl_in, good_b_in, good_a_in};
         s2_q <= s1_q;
         if (reg_wr && hit) sh_q[idx] <= reg_wdata;
      end
   end
   assign sel = {1'b1, s2_q[15], s2_q[12] & s2_q[13], s2_q[12], s2_q[13], s2_q[14], s2_q[11],
      s2_q[10]};
   assign req = sel[sh_q[1][4:2]] & (&(s2_q[7:0] | sh_q[0])) & (&(s2_q[9:8] | sh_q[1][1:0]));
   // ----
   // assertions
   // ----
   read_back_a: assert property (reg_rd && hit |=> reg_rdata == $past(shv))
      else $error("read data differs from stored value");
   rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
      else $error("read data without a read");
   unmapped_read_a: assert property (reg_rd && !hit && reg_addr != `RESQ_OFS_STATUS |=>
      reg_rdata == 8'h00) else $error("unmapped read not zero");
   rise_cause_a: assert property ($rose(rail3_enable) |-> $past(req))
      else $error("enable rose without request");
   fall_cause_a: assert property ($fell(rail3_enable) |-> !$past(req))
      else $error("enable fell with request");
   rise_prompt_a: assert property (
      !rail3_enable && req && sh_q[2][2:0] == 3'b000 ##1 req |=> rail3_enable)
      else $error("undelayed rise late");
   fall_prompt_a: assert property (
      rail3_enable && !req && sh_q[2][5:3] == 3'b000 ##1 !req |=> !rail3_enable)
      else $error("undelayed fall late");
   rise_hold_a: assert property (
      UNIT_CYC > 8 && $rose(req) && !rail3_enable && sh_q[2][2:0] != 3'b000 |=>
      !rail3_enable [*8]) else $error("rise too early");
   fall_hold_a: assert property (
      UNIT_CYC > 8 && $fell(req) && rail3_enable && sh_q[2][5:3] != 3'b000 |=>
      rail3_enable [*8]) else $error("fall too early");
   cover property ($rose(rail3_enable));
   cover property ($fell(rail3_enable));
   cover property (reg_rd && reg_addr == `RESQ_OFS_STATUS);
endmodule // resq_seq_properties

bind resq_rail_enable_sequencer resq_seq_properties #(.UNIT_CYC(UNIT_CYC)) u_props (
   .clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ctl_in(ctl_in), .good_a_in(good_a_in),
   .good_b_in(good_b_in), .rail3_enable(rail3_enable));

// ### resq_far_side.sv
// far side: control pins and the other rails' power-good monitors
// assumes the bench sets wanted levels {ctl, good_b, good_a} and a lag
`timescale 1ns/1ps
module resq_far_side
   import resq_pkg::*;
(
   input wire logic clock,
   input wire logic [15:0] want,
   input wire logic [1:0] lag,
   output resq_ctl_t ctl_in,
   output resq_good_a_t good_a_in,
   output resq_good_b_t good_b_in
);
   logic [15:0] pipe_q [3];
   always_ff @(posedge clock) begin
      pipe_q[0] <= want;
      pipe_q[1] <= pipe_q[0];
      pipe_q[2] <= pipe_q[1];
   end
   // a slow monitor answers up to three cycles late
   assign {ctl_in, good_b_in, good_a_in} = (lag == 2'd0) ? want : pipe_q[lag - 2'd1];
endmodule // resq_far_side

// ### tb_top.sv
// self-checking bench for the rail enable sequencer
// assumes the far-side model drives every pin; registers go through the plain port
`timescale 1ns/1ps
`include "resq_consts.svh"
module tb_top;
   localparam int unsigned UC = 10;
   logic clock = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, rd_q = 1'b0, rail;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
   logic [15:0] want = 16'h0000;
   logic [1:0] lag = 2'd0;
   logic [8:0] e;
   logic [8:0] expq [$];
   int failures = 0, checked = 0;
   resq_pkg::resq_ctl_t ctl_w;
   resq_pkg::resq_good_a_t ga_w;
   resq_pkg::resq_good_b_t gb_w;
   always #10 clock = ~clock;
   resq_rail_enable_sequencer #(.UNIT_CYC(UC)) u_dut (.clock(clock), .rst(rst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .ctl_in(ctl_w), .good_a_in(ga_w), .good_b_in(gb_w),
      .rail3_enable(rail));
   resq_far_side u_far (.clock(clock), .want(want), .lag(lag), .ctl_in(ctl_w),
      .good_a_in(ga_w), .good_b_in(gb_w));
   // ----
   // shared tasks
   // ----
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [8:0] x);
      @(posedge clock);
      reg_rd <= 1'b1;
      reg_addr <= a;
      expq.push_back(x);
      @(posedge clock);
      reg_rd <= 1'b0;
   endtask
   // status read: the rail level is compared beside it
   task automatic st(input logic [7:0] x);
      rd(`RESQ_OFS_STATUS, {1'b1, x});
   endtask
   task automatic end_of_test();
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   always @(posedge clock) begin
      if (rd_q) begin
         e = expq.pop_front();
         chk(reg_rdata, e[7:0]);
         if (e[8]) chk({7'h00, rail}, {7'h00, e[1]});
      end
      rd_q = reg_rd;
   end
   initial begin
      repeat (100000) @(posedge clock);
      failures++;
      end_of_test();
   end
   // ----
   // scenarios
   // ----
   initial begin
      logic [7:0] ofs [4];
      int unsigned un [8];
      logic [7:0] v, sv;
      logic [9:0] mk;
      ofs = '{`RESQ_OFS_R3_MASK_A, `RESQ_OFS_R3_SRC_MASK_B, `RESQ_OFS_R3_DELAYS,
         `RESQ_OFS_R4_MASK_A};
      un = '{0, 1, 2, 4, 8, 12, 16, 32};
      v = 8'($urandom(32'h05462af4));
      repeat (4) @(posedge clock);
      rst <= 1'b0;
      foreach (ofs[i]) rd(ofs[i], 9'h000);
      foreach (ofs[i]) begin
         v = 8'($urandom);
         wr(ofs[i], v);
         rd(ofs[i], {1'b0, v});
      end
      wr(8'h55, 8'hff);
      rd(8'h55, 9'h000);
      // delays cleared first: opening the masks may start a rise with the random delay code
      wr(`RESQ_OFS_R3_DELAYS, 8'h00);
      wr(`RESQ_OFS_R3_MASK_A, 8'hff);
      for (int s = 0; s < 16; s++) begin
         want <= 16'($urandom);
         lag <= 2'($urandom);
         wr(`RESQ_OFS_R3_SRC_MASK_B, {3'b000, 3'(s), 2'b11});
         repeat (12) @(posedge clock);
         sv = {1'b1, want[15], want[12] & want[13], want[12], want[13], want[14], want[11],
            want[10]};
         st(sv[s % 8] ? 8'h06 : 8'h00);
      end
      lag <= 2'd0;
      for (int b = 0; b < 10; b++) begin
         want <= 16'hffff ^ (16'h0001 << b);
         mk = 10'h3ff ^ (10'h001 << b);
         wr(`RESQ_OFS_R3_MASK_A, mk[7:0]);
         wr(`RESQ_OFS_R3_SRC_MASK_B, {6'h07, mk[9:8]});
         repeat (8) @(posedge clock);
         st(8'h00);
         wr(`RESQ_OFS_R3_MASK_A, 8'hff);
         wr(`RESQ_OFS_R3_SRC_MASK_B, 8'h1f);
         repeat (8) @(posedge clock);
         st(8'h06);
      end
      // drop control input 1 first so the rail is off before the first timed rise
      want <= 16'h03ff;
      wr(`RESQ_OFS_R3_SRC_MASK_B, 8'h03);
      repeat (8) @(posedge clock);
      for (int k = 1; k < 8; k++) begin
         wr(`RESQ_OFS_R3_DELAYS, {2'b00, 3'(k), 3'(k)});
         want <= 16'h07ff;
         repeat (un[k] * UC) @(posedge clock);
         st(8'h05);
         repeat (un[k] + 6) @(posedge clock);
         st(8'h06);
         want <= 16'h03ff;
         repeat (un[k] * UC) @(posedge clock);
         st(8'h03);
         repeat (un[k] + 6) @(posedge clock);
         st(8'h00);
      end
      repeat (4) @(posedge clock);
      end_of_test();
   end
endmodule // tb_top
